// ==== logic/ccd_eval_defs.vh ====
// constants shared by the sensor evaluation timing generator and offset controller
// assumes inclusion by bare name from the logic directory
`ifndef CCD_EVAL_DEFS_VH
`define CCD_EVAL_DEFS_VH

// ==========================================================
// clock and tap line
`define CLK_PERIOD_NS      32'd20
`define TAP_STEP_PS        32'd2500
`define TAP_COUNT          10

// ==========================================================
// converter and offset loop
`define ADC_BITS           12
`define DARK_CODE          12'hFF0
`define BLK_COLS           11'h00A
`define CORR_LEN           8'h10

// ==========================================================
// frame geometry
`define FD_SKIP_HEAD       10'h100
`define FD_KEEP            10'h200
`define FD_SKIP_TAIL       10'h0F0
`define SHUTTER_LEN        8'h10
`define TRANSFER_LEN       8'h20

// ==========================================================
// exposure times in microseconds: setting, fast dump, outputs
`define EXP_S0_F0_O1 16'h8214
`define EXP_S0_F0_O2 16'h5078
`define EXP_S0_F1_O1 16'h5078
`define EXP_S0_F1_O2 16'h3750
`define EXP_S1_F0_O1 16'h4010
`define EXP_S1_F0_O2 16'h27B0
`define EXP_S1_F1_O1 16'h1770
`define EXP_S1_F1_O2 16'h1130
`define EXP_S2_F0_O1 16'h1F18
`define EXP_S2_F0_O2 16'h1360
`define EXP_S2_F1_O1 16'h0BB8
`define EXP_S2_F1_O2 16'h09EC
`define EXP_S3_F0_O1 16'h0E9C
`define EXP_S3_F0_O2 16'h0910
`define EXP_S3_F1_O1 16'h0744
`define EXP_S3_F1_O2 16'h0730
`define EXP_S4_F0_O1 16'h0650
`define EXP_S4_F0_O2 16'h03F8
`define EXP_S4_F1_O1 16'h06A4
`define EXP_S4_F1_O2 16'h06A4
`define EXP_S5_F0_O1 16'h0234
`define EXP_S5_F0_O2 16'h016A
`define EXP_S5_F1_O1 16'h0338
`define EXP_S5_F1_O2 16'h0338
`define EXP_S6_F0_O1 16'h012A
`define EXP_S6_F0_O2 16'h00C6
`define EXP_S6_F1_O1 16'h01CC
`define EXP_S6_F1_O2 16'h01CC
`define EXP_S7_F0_O1 16'h0044
`define EXP_S7_F0_O2 16'h0037
`define EXP_S7_F1_O1 16'h005D
`define EXP_S7_F1_O2 16'h005D

`endif

// ==== logic/offset_loop.v ====
// automatic black level controller for two converter channels
// assumes measure window and frame end come from the timing generator on the same clock
`timescale 1ns/1ps
`include "ccd_eval_defs.vh"

module offset_loop #(
  parameter PER_FRAME = 0
) (
  input  wire                   clk_in,
  input  wire                   rst_in,
  input  wire                   measure_in,
  input  wire                   frame_end_in,
  input  wire [`ADC_BITS-1:0]   adc_a_in,
  input  wire [`ADC_BITS-1:0]   adc_b_in,
  output reg                    drive_en_a_out,
  output reg                    raise_a_out,
  output reg                    drive_en_b_out,
  output reg                    raise_b_out
);

  // ==========================================================
  // comparison against the dark code: {enable, raise}
  function [1:0] steer;
    input [`ADC_BITS-1:0] code;
    begin
      if (code > `DARK_CODE)
        steer = 2'h2;
      else if (code < `DARK_CODE)
        steer = 2'h3;
      else
        steer = 2'h0;
    end
  endfunction

  reg signed [15:0] err_a_reg;
  reg signed [15:0] err_b_reg;
  reg [7:0]         hold_reg;
  wire [1:0]        dir_a = steer(adc_a_in);
  wire [1:0]        dir_b = steer(adc_b_in);

  // ==========================================================
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      drive_en_a_out <= 1'b0;
      raise_a_out    <= 1'b0;
      drive_en_b_out <= 1'b0;
      raise_b_out    <= 1'b0;
      err_a_reg      <= 16'sh0000;
      err_b_reg      <= 16'sh0000;
      hold_reg       <= 8'h00;
    end else if (PER_FRAME == 0) begin
      // drive only inside the dark window, each channel on its own result
      drive_en_a_out <= measure_in & dir_a[1];
      raise_a_out    <= measure_in & dir_a[0];
      drive_en_b_out <= measure_in & dir_b[1];
      raise_b_out    <= measure_in & dir_b[0];
    end else begin
      // accumulate error over the frame, correct once at frame end
      if (frame_end_in) begin
        raise_a_out    <= err_a_reg > 16'sh0000;
        raise_b_out    <= err_b_reg > 16'sh0000;
        drive_en_a_out <= err_a_reg != 16'sh0000;
        drive_en_b_out <= err_b_reg != 16'sh0000;
        hold_reg       <= `CORR_LEN;
        err_a_reg      <= 16'sh0000;
        err_b_reg      <= 16'sh0000;
      end else begin
        if (measure_in && dir_a[1])
          err_a_reg <= dir_a[0] ? err_a_reg + 16'sh0001 : err_a_reg - 16'sh0001;
        if (measure_in && dir_b[1])
          err_b_reg <= dir_b[0] ? err_b_reg + 16'sh0001 : err_b_reg - 16'sh0001;
        if (hold_reg != 8'h00)
          hold_reg <= hold_reg - 8'h01;
        else begin
          drive_en_a_out <= 1'b0;
          drive_en_b_out <= 1'b0;
        end
      end
    end
  end

endmodule // offset_loop

// ==== logic/ccd_eval_timing_offset_ctrl.v ====
// sensor evaluation board control: frame timing generator with offset loop
// assumes switches and converter codes are synchronous to clk_in and that
// delay_taps_in carries the system clock delayed in steps of one tap each
`timescale 1ns/1ps
`include "ccd_eval_defs.vh"

module ccd_eval_timing_offset_ctrl #(
  parameter H_TOTAL       = 1100,
  parameter H_ACTIVE      = 1028,
  parameter DUMP_LEN      = 40,
  parameter ROWS          = 1008,
  parameter BLK_FIRST_COL = 9,
  parameter CLK_MHZ       = 1000 / `CLK_PERIOD_NS,
  parameter PER_FRAME     = 0
) (
  input  wire                   clk_in,
  input  wire                   rst_in,
  input  wire                   fast_dump_on_in,
  input  wire                   dual_output_in,
  input  wire                   progressive_in,
  input  wire [2:0]             exposure_sel_in,
  input  wire [`TAP_COUNT-1:0]  delay_taps_in,
  input  wire [`ADC_BITS-1:0]   adc_a_in,
  input  wire [`ADC_BITS-1:0]   adc_b_in,
  output wire                   hclk_out,
  output wire                   hclk_last_phase_right_out,
  output wire                   hclk_last_phase_left_out,
  output wire                   reset_pulse_out,
  output wire                   transfer_pulse_out,
  output wire                   sample_pulse_a_out,
  output wire                   sample_pulse_b_out,
  output reg                    vshift_out,
  output reg                    transfer_gate_out,
  output reg                    shutter_out,
  output reg                    fast_line_discard_out,
  output reg                    black_level_measure_out,
  output reg  [`ADC_BITS-1:0]   data_a_p_out,
  output reg  [`ADC_BITS-1:0]   data_a_n_out,
  output reg  [`ADC_BITS-1:0]   data_b_p_out,
  output reg  [`ADC_BITS-1:0]   data_b_n_out,
  output reg                    pixel_sync_p_out,
  output reg                    pixel_sync_n_out,
  output reg                    line_sync_p_out,
  output reg                    line_sync_n_out,
  output reg                    frame_sync_p_out,
  output reg                    frame_sync_n_out,
  output reg                    field_index_out,
  output wire                   offset_drive_en_a_out,
  output wire                   offset_raise_a_out,
  output wire                   offset_drive_en_b_out,
  output wire                   offset_raise_b_out
);

  localparam [1:0] ST_SHUTTER  = 2'h0;
  localparam [1:0] ST_EXPOSE   = 2'h1;
  localparam [1:0] ST_TRANSFER = 2'h2;
  localparam [1:0] ST_READ     = 2'h3;

  // ==========================================================
  // helpers
  function [10:0] gray2bin;
    input [10:0] g;
    integer i;
    begin
      gray2bin[10] = g[10];
      for (i = 9; i >= 0; i = i - 1)
        gray2bin[i] = gray2bin[i+1] ^ g[i];
    end
  endfunction

  function [10:0] bin2gray;
    input [10:0] b;
    begin
      bin2gray = b ^ (b >> 1);
    end
  endfunction

  function [15:0] exposure_us;
    input [4:0] idx;
    begin
      case (idx)
        5'h00: exposure_us = `EXP_S0_F0_O1;
        5'h01: exposure_us = `EXP_S0_F0_O2;
        5'h02: exposure_us = `EXP_S0_F1_O1;
        5'h03: exposure_us = `EXP_S0_F1_O2;
        5'h04: exposure_us = `EXP_S1_F0_O1;
        5'h05: exposure_us = `EXP_S1_F0_O2;
        5'h06: exposure_us = `EXP_S1_F1_O1;
        5'h07: exposure_us = `EXP_S1_F1_O2;
        5'h08: exposure_us = `EXP_S2_F0_O1;
        5'h09: exposure_us = `EXP_S2_F0_O2;
        5'h0A: exposure_us = `EXP_S2_F1_O1;
        5'h0B: exposure_us = `EXP_S2_F1_O2;
        5'h0C: exposure_us = `EXP_S3_F0_O1;
        5'h0D: exposure_us = `EXP_S3_F0_O2;
        5'h0E: exposure_us = `EXP_S3_F1_O1;
        5'h0F: exposure_us = `EXP_S3_F1_O2;
        5'h10: exposure_us = `EXP_S4_F0_O1;
        5'h11: exposure_us = `EXP_S4_F0_O2;
        5'h12: exposure_us = `EXP_S4_F1_O1;
        5'h13: exposure_us = `EXP_S4_F1_O2;
        5'h14: exposure_us = `EXP_S5_F0_O1;
        5'h15: exposure_us = `EXP_S5_F0_O2;
        5'h16: exposure_us = `EXP_S5_F1_O1;
        5'h17: exposure_us = `EXP_S5_F1_O2;
        5'h18: exposure_us = `EXP_S6_F0_O1;
        5'h19: exposure_us = `EXP_S6_F0_O2;
        5'h1A: exposure_us = `EXP_S6_F1_O1;
        5'h1B: exposure_us = `EXP_S6_F1_O2;
        5'h1C: exposure_us = `EXP_S7_F0_O1;
        5'h1D: exposure_us = `EXP_S7_F0_O2;
        5'h1E: exposure_us = `EXP_S7_F1_O1;
        default: exposure_us = `EXP_S7_F1_O2;
      endcase
    end
  endfunction

  // ==========================================================
  // state
  reg [1:0]  state_reg;
  reg [23:0] timer_reg;
  reg [10:0] col_gray_reg;
  reg [10:0] row_gray_reg;
  reg        prog_reg;
  reg        fd_reg;
  reg        dual_reg;
  reg        hgate_reg;
  reg [1:0]  frame_end_reg;

  wire [10:0] col_bin    = gray2bin(col_gray_reg);
  wire [10:0] row_bin    = gray2bin(row_gray_reg);
  wire        dump_line  = fd_reg && (row_bin[9:0] < `FD_SKIP_HEAD ||
                           row_bin[9:0] >= (`FD_SKIP_HEAD + `FD_KEEP));
  wire [10:0] line_last  = dump_line ? DUMP_LEN[10:0] - 11'h001 : H_TOTAL[10:0] - 11'h001;
  wire [10:0] rows_last  = prog_reg ? ROWS[10:0] - 11'h001 : ROWS[11:1] - 11'h001;
  wire        col_end    = col_bin == line_last;
  wire        row_end    = row_bin == rows_last;
  wire        reading    = state_reg == ST_READ;
  wire        live_line  = reading && !dump_line;
  wire [23:0] exp_cycles = exposure_us({exposure_sel_in, fast_dump_on_in, dual_output_in}) * CLK_MHZ[7:0];

  // ==========================================================
  // frame sequencer
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg       <= ST_SHUTTER;
      timer_reg       <= 24'h000000;
      col_gray_reg    <= 11'h000;
      row_gray_reg    <= 11'h000;
      prog_reg        <= 1'b1;
      fd_reg          <= 1'b0;
      dual_reg        <= 1'b0;
      field_index_out <= 1'b0;
      frame_end_reg   <= 2'h0;
    end else begin
      frame_end_reg <= {frame_end_reg[0], reading && col_end && row_end};
      case (state_reg)
        ST_SHUTTER: begin
          timer_reg <= timer_reg + 24'h000001;
          if (timer_reg[7:0] == `SHUTTER_LEN - 8'h01) begin
            timer_reg <= exp_cycles;
            state_reg <= ST_EXPOSE;
          end
        end
        ST_EXPOSE: begin
          timer_reg <= timer_reg - 24'h000001;
          if (timer_reg <= 24'h000001) begin
            timer_reg <= 24'h000000;
            state_reg <= ST_TRANSFER;
          end
        end
        ST_TRANSFER: begin
          timer_reg <= timer_reg + 24'h000001;
          if (timer_reg[7:0] == `TRANSFER_LEN - 8'h01) begin
            timer_reg    <= 24'h000000;
            state_reg    <= ST_READ;
            col_gray_reg <= 11'h000;
            row_gray_reg <= 11'h000;
            prog_reg     <= progressive_in;
            fd_reg       <= fast_dump_on_in & progressive_in;
            dual_reg     <= dual_output_in;
          end
        end
        ST_READ: begin
          if (col_end) begin
            col_gray_reg <= 11'h000;
            row_gray_reg <= bin2gray(row_bin + 11'h001);
            if (row_end) begin
              if (prog_reg) begin
                state_reg       <= ST_SHUTTER;
                field_index_out <= 1'b0;
              end else begin
                state_reg       <= ST_TRANSFER;
                field_index_out <= ~field_index_out;
              end
            end
          end else
            col_gray_reg <= bin2gray(col_bin + 11'h001);
        end
        default: state_reg <= ST_SHUTTER;
      endcase
    end
  end

  // ==========================================================
  // line strobes and sensor controls
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hgate_reg               <= 1'b0;
      vshift_out              <= 1'b0;
      transfer_gate_out       <= 1'b0;
      shutter_out             <= 1'b0;
      fast_line_discard_out   <= 1'b0;
      black_level_measure_out <= 1'b0;
    end else begin
      hgate_reg               <= live_line && col_bin < H_ACTIVE[10:0];
      vshift_out              <= reading && col_end;
      transfer_gate_out       <= state_reg == ST_TRANSFER;
      shutter_out             <= state_reg == ST_SHUTTER && prog_reg;
      fast_line_discard_out   <= reading && dump_line;
      black_level_measure_out <= live_line && col_bin >= BLK_FIRST_COL[10:0] &&
                                 col_bin < BLK_FIRST_COL[10:0] + `BLK_COLS;
    end
  end

  // ==========================================================
  // counter-free pulse forming from the tap line
  wire h_phase = hgate_reg & delay_taps_in[0];
  assign hclk_out                  = h_phase;
  assign hclk_last_phase_right_out = hgate_reg & (delay_taps_in[0] ^ ~dual_reg);
  assign hclk_last_phase_left_out  = hgate_reg & (delay_taps_in[0] ^ dual_reg);
  assign reset_pulse_out    = hgate_reg & delay_taps_in[1] & ~delay_taps_in[2];
  assign transfer_pulse_out = hgate_reg & (delay_taps_in[3] & ~delay_taps_in[5]);
  assign sample_pulse_a_out = hgate_reg & delay_taps_in[6] & ~delay_taps_in[7];
  assign sample_pulse_b_out = hgate_reg & ~delay_taps_in[8] & delay_taps_in[9];

  // ==========================================================
  // output connector
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_a_p_out     <= 12'h000;
      data_a_n_out     <= 12'hFFF;
      data_b_p_out     <= 12'h000;
      data_b_n_out     <= 12'hFFF;
      pixel_sync_p_out <= 1'b0;
      pixel_sync_n_out <= 1'b1;
      line_sync_p_out  <= 1'b0;
      line_sync_n_out  <= 1'b1;
      frame_sync_p_out <= 1'b0;
      frame_sync_n_out <= 1'b1;
    end else begin
      data_a_p_out     <= ~adc_a_in;
      data_a_n_out     <= adc_a_in;
      data_b_p_out     <= ~adc_b_in;
      data_b_n_out     <= adc_b_in;
      pixel_sync_p_out <= hgate_reg;
      pixel_sync_n_out <= ~hgate_reg;
      line_sync_p_out  <= live_line;
      line_sync_n_out  <= ~live_line;
      frame_sync_p_out <= reading;
      frame_sync_n_out <= ~reading;
    end
  end

  // ==========================================================
  offset_loop #(
    .PER_FRAME (PER_FRAME)
  ) u_offset_loop (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .measure_in     (black_level_measure_out),
    .frame_end_in   (frame_end_reg[1]),
    .adc_a_in       (adc_a_in),
    .adc_b_in       (adc_b_in),
    .drive_en_a_out (offset_drive_en_a_out),
    .raise_a_out    (offset_raise_a_out),
    .drive_en_b_out (offset_drive_en_b_out),
    .raise_b_out    (offset_raise_b_out)
  );

endmodule // ccd_eval_timing_offset_ctrl

// ==== verification/ccd_sensor_model.sv ====
// sensor and converter model: tapped clock delay line and two converter channels
// assumes the bench sets the code that each converter reports
`timescale 1ns/1ps
`include "ccd_eval_defs.vh"

module ccd_sensor_model (
  input  wire                   clk_in,
  input  wire [`ADC_BITS-1:0]   level_a_in,
  input  wire [`ADC_BITS-1:0]   level_b_in,
  output reg  [`ADC_BITS-1:0]   adc_a_out,
  output reg  [`ADC_BITS-1:0]   adc_b_out,
  output wire [`TAP_COUNT-1:0]  taps_out
);
  genvar k;
  // ==========================================================
  // delay line, each tap a further 2.5 ns behind the clock
  assign #2.5 taps_out[0] = clk_in;
  generate
    for (k = 1; k < `TAP_COUNT; k = k + 1) begin : g_tap
      assign #2.5 taps_out[k] = taps_out[k-1];
    end
  endgenerate
  // ==========================================================
  // converters launch a new code just after each rising edge
  initial begin
    adc_a_out = 12'hFF0;
    adc_b_out = 12'hFF0;
  end
  always @(posedge clk_in) begin
    adc_a_out <= level_a_in;
    adc_b_out <= level_b_in;
  end
endmodule // ccd_sensor_model

// ==== verification/ccd_eval_chk_sva.sv ====
// checker: output data, sync pairs, measure window and offset steering
// assumes one clk_in domain and per-line offset correction
`timescale 1ns/1ps
`include "ccd_eval_defs.vh"

module ccd_eval_chk (
  input wire                 clk_in,
  input wire                 rst_in,
  input wire [`ADC_BITS-1:0] adc_a_in,
  input wire [`ADC_BITS-1:0] adc_b_in,
  input wire [`ADC_BITS-1:0] data_a_p_out,
  input wire [`ADC_BITS-1:0] data_a_n_out,
  input wire [`ADC_BITS-1:0] data_b_p_out,
  input wire [`ADC_BITS-1:0] data_b_n_out,
  input wire                 pixel_sync_p_out,
  input wire                 pixel_sync_n_out,
  input wire                 line_sync_p_out,
  input wire                 line_sync_n_out,
  input wire                 frame_sync_p_out,
  input wire                 frame_sync_n_out,
  input wire                 fast_line_discard_out,
  input wire                 black_level_measure_out,
  input wire                 offset_drive_en_a_out,
  input wire                 offset_raise_a_out,
  input wire                 offset_drive_en_b_out,
  input wire                 offset_raise_b_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // ==========================================================
  // length of the current measure window, saturating
  reg [4:0] run_len;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in)
      run_len <= 5'h00;
    else if (black_level_measure_out && run_len != 5'h1F)
      run_len <= run_len + 5'h01;
    else if (!black_level_measure_out)
      run_len <= 5'h00;
  end
  // ==========================================================
  // sequences
  sequence s_window;
    run_len == 5'h0A;
  endsequence
  sequence s_idle;
    !offset_drive_en_a_out && !offset_drive_en_b_out;
  endsequence
  // ==========================================================
  // assertions
  inv_data_a_a: assert property (!$past(rst_in) |->
    data_a_p_out == ~$past(adc_a_in) && data_a_n_out == $past(adc_a_in))
    else $error("channel a data not inverted");
  inv_data_b_a: assert property (!$past(rst_in) |->
    data_b_p_out == ~$past(adc_b_in) && data_b_n_out == $past(adc_b_in))
    else $error("channel b data not inverted");
  steer_a_a: assert property (black_level_measure_out |=>
    offset_drive_en_a_out == ($past(adc_a_in) != 12'hFF0) && offset_raise_a_out == ($past(adc_a_in) < 12'hFF0))
    else $error("channel a offset steering wrong");
  steer_b_a: assert property (black_level_measure_out |=>
    offset_drive_en_b_out == ($past(adc_b_in) != 12'hFF0) && offset_raise_b_out == ($past(adc_b_in) < 12'hFF0))
    else $error("channel b offset steering wrong");
  hold_drive_a: assert property (!black_level_measure_out |=> s_idle)
    else $error("offset drive on outside window");
  window_len_a: assert property ($fell(black_level_measure_out) |-> s_window)
    else $error("measure window not ten columns");
  sync_pairs_a: assert property (pixel_sync_p_out != pixel_sync_n_out &&
    line_sync_p_out != line_sync_n_out && frame_sync_p_out != frame_sync_n_out)
    else $error("sync pair not complementary");
  discard_dead_a: assert property (fast_line_discard_out |-> !line_sync_p_out)
    else $error("dumped line marked live");
endmodule // ccd_eval_chk

bind ccd_eval_timing_offset_ctrl ccd_eval_chk u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .adc_a_in(adc_a_in), .adc_b_in(adc_b_in),
  .data_a_p_out(data_a_p_out), .data_a_n_out(data_a_n_out), .data_b_p_out(data_b_p_out),
  .data_b_n_out(data_b_n_out), .pixel_sync_p_out(pixel_sync_p_out), .pixel_sync_n_out(pixel_sync_n_out),
  .line_sync_p_out(line_sync_p_out), .line_sync_n_out(line_sync_n_out), .frame_sync_p_out(frame_sync_p_out),
  .frame_sync_n_out(frame_sync_n_out), .fast_line_discard_out(fast_line_discard_out),
  .black_level_measure_out(black_level_measure_out), .offset_drive_en_a_out(offset_drive_en_a_out),
  .offset_raise_a_out(offset_raise_a_out), .offset_drive_en_b_out(offset_drive_en_b_out),
  .offset_raise_b_out(offset_raise_b_out));

// ==== verification/ccd_eval_timing_offset_ctrl_tb_top.sv ====
// testbench: exposure, output mode, pulse forming, fast dump, interlace and offset loop
// assumes the sensor model supplies the tap line and converter codes
`timescale 1ns/1ps
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end

module ccd_eval_timing_offset_ctrl_tb_top;
  localparam int DUMP = 8, HT = 40, HA = 30, RS = 16, MHZ = 1;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        fd = 1'b0;
  logic        fd_on = 1'b1;
  logic        dual = 1'b0;
  logic        prog = 1'b1;
  logic [2:0]  sel = 3'h7;
  logic [11:0] lev_a = 12'hFF0;
  logic [11:0] lev_b = 12'hFF0;
  wire  [11:0] adc_a, adc_b;
  wire  [9:0]  taps;
  wire         hclk, hr, hl, rp, tp, sa, sb, tg, sh, disc, meas, fi, fs, ls, vs;
  wire         ena, ra, enb, rb, fd_fs, fd_ls, fd_disc;
  int          num_errors = 0;
  int          compares = 0;
  int          cycles = 0;

  always #10 clk_in = ~clk_in;

  ccd_sensor_model model (.clk_in(clk_in), .level_a_in(lev_a), .level_b_in(lev_b),
    .adc_a_out(adc_a), .adc_b_out(adc_b), .taps_out(taps));

  ccd_eval_timing_offset_ctrl #(.H_TOTAL(HT), .H_ACTIVE(HA), .DUMP_LEN(DUMP), .ROWS(RS), .CLK_MHZ(MHZ)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .fast_dump_on_in(fd), .dual_output_in(dual), .progressive_in(prog),
    .exposure_sel_in(sel), .delay_taps_in(taps), .adc_a_in(adc_a), .adc_b_in(adc_b), .hclk_out(hclk),
    .hclk_last_phase_right_out(hr), .hclk_last_phase_left_out(hl), .reset_pulse_out(rp),
    .transfer_pulse_out(tp), .sample_pulse_a_out(sa), .sample_pulse_b_out(sb), .vshift_out(vs),
    .transfer_gate_out(tg), .shutter_out(sh), .fast_line_discard_out(disc), .black_level_measure_out(meas),
    .data_a_p_out(), .data_a_n_out(), .data_b_p_out(), .data_b_n_out(), .pixel_sync_p_out(),
    .pixel_sync_n_out(), .line_sync_p_out(ls), .line_sync_n_out(), .frame_sync_p_out(fs),
    .frame_sync_n_out(), .field_index_out(fi), .offset_drive_en_a_out(ena), .offset_raise_a_out(ra),
    .offset_drive_en_b_out(enb), .offset_raise_b_out(rb));

  // full-height instance for the fast dump split
  ccd_eval_timing_offset_ctrl #(.H_TOTAL(HT), .H_ACTIVE(HA), .DUMP_LEN(DUMP), .CLK_MHZ(MHZ)) dut_fd (
    .clk_in(clk_in), .rst_in(rst_in), .fast_dump_on_in(fd_on), .dual_output_in(dual), .progressive_in(prog),
    .exposure_sel_in(sel), .delay_taps_in(taps), .adc_a_in(adc_a), .adc_b_in(adc_b), .hclk_out(),
    .hclk_last_phase_right_out(), .hclk_last_phase_left_out(), .reset_pulse_out(), .transfer_pulse_out(),
    .sample_pulse_a_out(), .sample_pulse_b_out(), .vshift_out(), .transfer_gate_out(), .shutter_out(),
    .fast_line_discard_out(fd_disc), .black_level_measure_out(), .data_a_p_out(), .data_a_n_out(),
    .data_b_p_out(), .data_b_n_out(), .pixel_sync_p_out(), .pixel_sync_n_out(), .line_sync_p_out(fd_ls),
    .line_sync_n_out(), .frame_sync_p_out(fd_fs), .frame_sync_n_out(), .field_index_out(),
    .offset_drive_en_a_out(), .offset_raise_a_out(), .offset_drive_en_b_out(), .offset_raise_b_out());

  // ==========================================================
  // helpers
  function automatic logic pick(input int w);
    case (w)
      0: pick = sh;
      1: pick = tg;
      2: pick = fs;
      3: pick = meas;
      4: pick = ls;
      default: pick = fd_fs;
    endcase
  endfunction

  task automatic wait_for(input int w, input logic v);
    int n;
    n = 0;
    while (pick(w) !== v && n < 30000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    `CHECK(pick(w), v)
  endtask

  task automatic results;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 80000) begin
      num_errors++;
      results();
    end
  end

  // ==========================================================
  // scenarios
  task automatic t_fast_dump;
    int head, tail, lines;
    head = 0;
    tail = 0;
    lines = 0;
    wait_for(5, 1'b1);
    // line sync stays high across consecutive live lines, so count its cycles
    while (fd_fs === 1'b1) begin
      if (fd_disc === 1'b1 && lines == 0) head++;
      if (fd_disc === 1'b1 && lines != 0) tail++;
      if (fd_ls === 1'b1) lines++;
      @(posedge clk_in);
      #1;
    end
    `CHECK(head, 32'h100 * DUMP)
    `CHECK(lines, 32'h200 * HT)
    `CHECK(tail, 32'hF0 * DUMP)
  endtask

  // tap-formed outputs sampled inside one pixel of a live line
  task automatic t_pulses(input logic d);
    wait_for(4, 1'b1);
    repeat (4) @(posedge clk_in);
    #3;
    `CHECK({hclk, hr, hl}, {1'b1, d, ~d})
    #3;
    `CHECK({rp, sa}, 2'b10)
    #6;
    `CHECK(tp, 1'b1)
    #1;
    `CHECK(sb, 1'b1)
    #5.5;
    `CHECK(sa, 1'b1)
  endtask

  task automatic t_expose(input logic [2:0] s, input logic f, input logic d, input logic [15:0] us);
    int n;
    wait_for(2, 1'b1);
    @(posedge clk_in);
    sel <= s;
    fd <= f;
    dual <= d;
    wait_for(1, 1'b1);
    wait_for(2, 1'b1);
    if (!f) t_pulses(d);
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    n = 0;
    while (tg !== 1'b1 && n < 2000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    `CHECK(16'(n), us)
  endtask

  task automatic t_off_case(input logic [11:0] a, input logic [11:0] b);
    @(posedge clk_in);
    lev_a <= a;
    lev_b <= b;
    wait_for(3, 1'b0);
    wait_for(3, 1'b1);
    repeat (2) @(posedge clk_in);
    #1;
    `CHECK({ena, ra}, {a != 12'hFF0, a < 12'hFF0})
    `CHECK({enb, rb}, {b != 12'hFF0, b < 12'hFF0})
    wait_for(3, 1'b0);
    @(posedge clk_in);
    #1;
    `CHECK({ena, enb}, 2'b00)
  endtask

  task automatic t_per_line;
    int wins, shifts;
    logic prev;
    wins = 0;
    shifts = 0;
    prev = 1'b0;
    wait_for(2, 1'b0);
    wait_for(2, 1'b1);
    while (fs === 1'b1) begin
      if (meas === 1'b1 && prev === 1'b0) wins++;
      if (vs === 1'b1) shifts++;
      prev = meas;
      @(posedge clk_in);
      #1;
    end
    `CHECK(wins, 32'h10)
    `CHECK(shifts, 32'h10)
  endtask

  task automatic t_interlace;
    int lines, bad, r;
    logic pf, f0;
    lines = 0;
    bad = 0;
    r = 0;
    pf = 1'b1;
    f0 = 1'b0;
    wait_for(2, 1'b1);
    @(posedge clk_in);
    prog <= 1'b0;
    fd <= 1'b1;
    wait_for(1, 1'b1);
    wait_for(1, 1'b0);
    while (r < 3) begin
      if (sh !== 1'b0 || disc !== 1'b0) bad++;
      if (fs === 1'b1 && pf === 1'b0) r++;
      if (fs === 1'b1 && pf === 1'b0 && r == 1) f0 = fi;
      if (fs === 1'b1 && pf === 1'b0 && r == 2) `CHECK(fi, ~f0)
      if (r > 0 && r < 3 && ls === 1'b1) lines++;
      pf = fs;
      @(posedge clk_in);
      #1;
    end
    `CHECK(lines, 32'h10 * HT)
    `CHECK(bad, 32'h0)
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    t_fast_dump();
    t_expose(3'h7, 1'b1, 1'b1, 16'h005D);
    t_expose(3'h7, 1'b1, 1'b0, 16'h005D);
    t_expose(3'h7, 1'b0, 1'b1, 16'h0037);
    t_expose(3'h7, 1'b0, 1'b0, 16'h0044);
    t_expose(3'h6, 1'b1, 1'b1, 16'h01CC);
    t_expose(3'h6, 1'b1, 1'b0, 16'h01CC);
    t_expose(3'h6, 1'b0, 1'b1, 16'h00C6);
    t_expose(3'h6, 1'b0, 1'b0, 16'h012A);
    t_off_case(12'hFF5, 12'hFE0);
    t_off_case(12'hFF0, 12'hFF0);
    t_off_case(12'hFEF, 12'hFF1);
    t_per_line();
    t_interlace();
    results();
  end
endmodule // ccd_eval_timing_offset_ctrl_tb_top
